// >>> rtl/cmp_sync.sv
// three-stage synchroniser with agreement filter for the raw comparator result
`timescale 1ns/100ps
`include "cmp_consts.svh"

module cmp_sync
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic nxt_level;

   // the level follows only when stages two and three agree
   always_comb
   begin
      nxt_level = level_ff;
      if (s2_ff == s3_ff)
      begin
         nxt_level = s3_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         level_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         level_ff <= nxt_level;
      end
   end

   assign sync_out = level_ff;

endmodule : cmp_sync

// >>> rtl/comparator_irq_mux_ctrl.sv
// digital control around the analog comparator: sync, edge interrupt, input mux, capture link
//
// Contract
// - set flag on edge picked by mode
// - request only with flag, enable, global enable
// - vector taken clears the flag
// - writing one clears flag, zero keeps
// - enable bit gates the comparator interrupt
// - link bit feeds output to capture
// - link off disconnects capture path fully
// - modes: toggle, reserved, falling, rising
// - mux on, converter off: channel drives negative
// - otherwise dedicated negative pin is used
// - raw result synchronised before output bit
// - output high when positive exceeds negative
// - bandgap select replaces positive pin
// - disable bit switches comparator off
`timescale 1ns/100ps
`include "cmp_consts.svh"

module comparator_irq_mux_ctrl
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input cmp_pkg::bus_req_t bus_req,
   output logic [`CMP_DATA_W-1:0] rdata,
   input wire logic cmp_raw,
   input wire logic converter_enable,
   input wire logic [`CMP_CHAN_W-1:0] channel_select,
   input wire logic global_irq_enable,
   input wire logic vector_ack,
   output logic cmp_irq_req,
   output logic irq,
   output logic capture_trigger,
   output cmp_pkg::analog_ctrl_t analog_ctrl
);

   import cmp_pkg::*;

   // synchronised comparator result and its history
   logic cmp_output;
   logic prev_ff;
   logic nxt_prev;
   logic rise_evt;
   logic fall_evt;
   logic mode_evt;

   // control and flag state
   ctrl_t ctrl_ff;
   ctrl_t nxt_ctrl;
   logic mux_en_ff;
   logic nxt_mux_en;
   logic flag_ff;
   logic nxt_flag;

   // event status, enable and read data
   logic [`CMP_EVT_W-1:0] evt_stat_ff;
   logic [`CMP_EVT_W-1:0] nxt_evt_stat;
   logic [`CMP_EVT_W-1:0] evt_en_ff;
   logic [`CMP_EVT_W-1:0] nxt_evt_en;
   logic [`CMP_EVT_W-1:0] evt_set;
   logic [`CMP_EVT_W-1:0] evt_clr;
   logic [`CMP_DATA_W-1:0] rdata_ff;
   logic [`CMP_DATA_W-1:0] nxt_rdata;

   // outputs toward the analog side and the timer
   analog_ctrl_t analog_ff;
   analog_ctrl_t nxt_analog;
   logic capture_ff;
   logic nxt_capture;
   logic req_ff;
   logic nxt_req;

   // decoded bus strobes
   logic wr_ctrl;
   logic wr_mux;
   logic wr_evt_clr;
   logic wr_evt_en;

   // the comparator drives high when positive exceeds negative; no inversion here
   cmp_sync u_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(cmp_raw),
      .sync_out(cmp_output)
   );

   // edge detection against the value one clock earlier
   always_comb
   begin
      nxt_prev = cmp_output;
      rise_evt = cmp_output & ~prev_ff;
      fall_evt = ~cmp_output & prev_ff;
      case (ctrl_ff.irq_mode)
         MODE_TOGGLE: mode_evt = rise_evt | fall_evt;
         MODE_FALL: mode_evt = fall_evt;
         MODE_RISE: mode_evt = rise_evt;
         MODE_RSVD: mode_evt = 1'b0;
         default: mode_evt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= nxt_prev;
      end
   end

   // address decode for writes
   always_comb
   begin
      wr_ctrl = bus_req.wr && (bus_req.addr == `CMP_OFS_CTRL);
      wr_mux = bus_req.wr && (bus_req.addr == `CMP_OFS_MUX);
      wr_evt_clr = bus_req.wr && (bus_req.addr == `CMP_OFS_EVT_CLR);
      wr_evt_en = bus_req.wr && (bus_req.addr == `CMP_OFS_EVT_EN);
   end

   // control register; the output bit and the flag are not stored by a write
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_mux_en = mux_en_ff;
      if (wr_ctrl)
      begin
         nxt_ctrl.cmp_disable = bus_req.wdata[`CMP_BIT_DISABLE];
         nxt_ctrl.cmp_bandgap_select = bus_req.wdata[`CMP_BIT_BANDGAP];
         nxt_ctrl.cmp_irq_enable = bus_req.wdata[`CMP_BIT_IRQ_EN];
         nxt_ctrl.cmp_capture_link_en = bus_req.wdata[`CMP_BIT_LINK];
         // a mode change with the enable still set may flag an edge; software avoids that
         nxt_ctrl.irq_mode = irq_mode_t'(bus_req.wdata[`CMP_BIT_MODE_HI:`CMP_BIT_MODE_LO]);
      end
      if (wr_mux)
      begin
         nxt_mux_en = bus_req.wdata[`CMP_BIT_MUX_EN];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_ff <= '0;
         mux_en_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         mux_en_ff <= nxt_mux_en;
      end
   end

   // comparator flag: a new edge wins over a clear in the same cycle
   always_comb
   begin
      nxt_flag = flag_ff;
      if (vector_ack)
      begin
         nxt_flag = 1'b0;
      end
      if (wr_ctrl && bus_req.wdata[`CMP_BIT_FLAG])
      begin
         nxt_flag = 1'b0;
      end
      if (mode_evt)
      begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_ff <= 1'b0;
      end
      else
      begin
         flag_ff <= nxt_flag;
      end
   end

   // sticky event status, write-one-to-clear register and enable register
   always_comb
   begin
      evt_set = `CMP_EVT_RST;
      evt_set[`CMP_EVT_MODE] = mode_evt;
      evt_set[`CMP_EVT_RISE] = rise_evt;
      evt_set[`CMP_EVT_FALL] = fall_evt;
      evt_clr = wr_evt_clr ? bus_req.wdata[`CMP_EVT_W-1:0] : `CMP_EVT_RST;
      nxt_evt_stat = (evt_stat_ff & ~evt_clr) | evt_set;
      nxt_evt_en = evt_en_ff;
      if (wr_evt_en)
      begin
         nxt_evt_en = bus_req.wdata[`CMP_EVT_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_stat_ff <= `CMP_EVT_RST;
         evt_en_ff <= `CMP_EVT_RST;
      end
      else
      begin
         evt_stat_ff <= nxt_evt_stat;
         evt_en_ff <= nxt_evt_en;
      end
   end

   // read data stands only in the cycle after the read strobe
   always_comb
   begin
      nxt_rdata = `CMP_DATA_ZERO;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            `CMP_OFS_CTRL:
            begin
               nxt_rdata[`CMP_BIT_DISABLE] = ctrl_ff.cmp_disable;
               nxt_rdata[`CMP_BIT_BANDGAP] = ctrl_ff.cmp_bandgap_select;
               nxt_rdata[`CMP_BIT_OUTPUT] = cmp_output;
               nxt_rdata[`CMP_BIT_FLAG] = flag_ff;
               nxt_rdata[`CMP_BIT_IRQ_EN] = ctrl_ff.cmp_irq_enable;
               nxt_rdata[`CMP_BIT_LINK] = ctrl_ff.cmp_capture_link_en;
               nxt_rdata[`CMP_BIT_MODE_HI:`CMP_BIT_MODE_LO] = ctrl_ff.irq_mode;
            end
            `CMP_OFS_MUX:
            begin
               nxt_rdata[`CMP_BIT_MUX_EN] = mux_en_ff;
            end
            `CMP_OFS_EVT_STAT:
            begin
               nxt_rdata[`CMP_EVT_W-1:0] = evt_stat_ff;
            end
            `CMP_OFS_EVT_EN:
            begin
               nxt_rdata[`CMP_EVT_W-1:0] = evt_en_ff;
            end
            default:
            begin
               nxt_rdata = `CMP_DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_ff <= `CMP_DATA_ZERO;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   // analog control, capture link and interrupt request
   always_comb
   begin
      nxt_analog.power_down = ctrl_ff.cmp_disable;
      nxt_analog.bandgap_sel = ctrl_ff.cmp_bandgap_select;
      // the converter owns the channel mux while it runs, so it must be off for the comparator to borrow it
      nxt_analog.neg_use_mux = mux_en_ff & ~converter_enable;
      nxt_analog.neg_channel = nxt_analog.neg_use_mux ? channel_select : `CMP_CHAN_RST;
      // link off forces zero so no comparator edge can reach the capture front end
      nxt_capture = ctrl_ff.cmp_capture_link_en & cmp_output;
      nxt_req = nxt_flag & nxt_ctrl.cmp_irq_enable & global_irq_enable;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         analog_ff <= '0;
         capture_ff <= 1'b0;
         req_ff <= 1'b0;
      end
      else
      begin
         analog_ff <= nxt_analog;
         capture_ff <= nxt_capture;
         req_ff <= nxt_req;
      end
   end

   assign rdata = rdata_ff;
   assign analog_ctrl = analog_ff;
   // timer still needs its own capture interrupt enable to raise a capture interrupt
   assign capture_trigger = capture_ff;
   assign cmp_irq_req = req_ff;
   assign irq = |(evt_stat_ff & evt_en_ff);

endmodule : comparator_irq_mux_ctrl

// >>> shared/cmp_consts.svh
// constants for the comparator control block: widths, offsets, field positions, reset values
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

`define CMP_ADDR_W 8
`define CMP_DATA_W 8
`define CMP_CHAN_W 3
`define CMP_EVT_W 3

`define CMP_OFS_CTRL 8'h00
`define CMP_OFS_MUX 8'h04
`define CMP_OFS_EVT_STAT 8'h08
`define CMP_OFS_EVT_CLR 8'h0C
`define CMP_OFS_EVT_EN 8'h10

`define CMP_BIT_DISABLE 7
`define CMP_BIT_BANDGAP 6
`define CMP_BIT_OUTPUT 5
`define CMP_BIT_FLAG 4
`define CMP_BIT_IRQ_EN 3
`define CMP_BIT_LINK 2
`define CMP_BIT_MODE_HI 1
`define CMP_BIT_MODE_LO 0
`define CMP_BIT_MUX_EN 0

`define CMP_EVT_MODE 0
`define CMP_EVT_RISE 1
`define CMP_EVT_FALL 2

`define CMP_MODE_TOGGLE 2'h0
`define CMP_MODE_RSVD 2'h1
`define CMP_MODE_FALL 2'h2
`define CMP_MODE_RISE 2'h3

`define CMP_DATA_ZERO 8'h00
`define CMP_EVT_RST 3'h0
`define CMP_CHAN_RST 3'h0

`endif

// >>> shared/cmp_pkg.sv
// types shared by the comparator control block and its users
`include "cmp_consts.svh"

package cmp_pkg;

   typedef enum logic [1:0]
   {
      MODE_TOGGLE = `CMP_MODE_TOGGLE,
      MODE_RSVD = `CMP_MODE_RSVD,
      MODE_FALL = `CMP_MODE_FALL,
      MODE_RISE = `CMP_MODE_RISE
   } irq_mode_t;

   typedef struct packed
   {
      logic [`CMP_ADDR_W-1:0] addr;
      logic [`CMP_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed
   {
      logic power_down;
      logic bandgap_sel;
      logic neg_use_mux;
      logic [`CMP_CHAN_W-1:0] neg_channel;
   } analog_ctrl_t;

   typedef struct packed
   {
      logic cmp_disable;
      logic cmp_bandgap_select;
      logic cmp_irq_enable;
      logic cmp_capture_link_en;
      irq_mode_t irq_mode;
   } ctrl_t;

endpackage : cmp_pkg

// >>> sim/cmp_analog_model.sv
// behavioural analog comparator that follows the negative input selection
`timescale 1ns/100ps
module cmp_analog_model
(
   input cmp_pkg::analog_ctrl_t analog_ctrl,
   input wire logic pin_above,
   input wire logic [7:0] chan_above,
   input wire logic capture_trigger,
   input wire logic capture_irq_enable,
   output logic cmp_raw,
   output logic capture_irq
);
   import cmp_pkg::*;
   // powered down reads as a steady low; no bandgap level is modelled
   assign cmp_raw = analog_ctrl.power_down ? 1'b0 :
      analog_ctrl.neg_use_mux ? chan_above[analog_ctrl.neg_channel] : pin_above;
   // timer side: a comparator capture only interrupts when software has set the timer's own enable
   assign capture_irq = capture_trigger & capture_irq_enable;
endmodule : cmp_analog_model

// >>> sim/cmp_ctrl_checker.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/100ps
`include "cmp_consts.svh"
module cmp_ctrl_checker
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input cmp_pkg::bus_req_t bus_req,
   input wire logic cmp_raw,
   input wire logic converter_enable,
   input wire logic [2:0] channel_select,
   input wire logic global_irq_enable,
   input wire logic vector_ack,
   input wire logic cmp_irq_req,
   input wire logic capture_trigger,
   input cmp_pkg::analog_ctrl_t analog_ctrl
);
   import cmp_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // the window spans the whole synchroniser delay, so a late event cannot undo a clear
   sequence s_quiet;
      $past(cmp_raw, 3) == $past(cmp_raw, 9);
   endsequence
   sequence s_raw_step;
      $past(cmp_raw, 3) != $past(cmp_raw, 9);
   endsequence
   property p_req_global;
      cmp_irq_req |-> $past(global_irq_enable);
   endproperty
   a_req_global: assert property (p_req_global) else $error("request without global enable");
   property p_req_drop;
      !global_irq_enable |=> !cmp_irq_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept after global disable");
   property p_req_edge;
      $rose(cmp_irq_req) && !$past(bus_req.wr) && $past(global_irq_enable, 2) |-> s_raw_step;
   endproperty
   a_req_edge: assert property (p_req_edge) else $error("request without comparator edge");
   property p_vec_clr;
      vector_ack ##0 s_quiet |=> !cmp_irq_req;
   endproperty
   a_vec_clr: assert property (p_vec_clr) else $error("vector taken but request stays");
   property p_w1c;
      bus_req.wr && bus_req.addr == `CMP_OFS_CTRL && bus_req.wdata[`CMP_BIT_FLAG] ##0 s_quiet |=> !cmp_irq_req;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag clear write ignored");
   property p_cap;
      capture_trigger |-> $past(cmp_raw, 5) || $past(cmp_raw, 6) || $past(cmp_raw, 7);
   endproperty
   a_cap: assert property (p_cap) else $error("capture trigger without comparator high");
   property p_mux_on;
      analog_ctrl.neg_use_mux |-> !$past(converter_enable) && analog_ctrl.neg_channel == $past(channel_select);
   endproperty
   a_mux_on: assert property (p_mux_on) else $error("wrong negative channel");
   property p_mux_off;
      $past(converter_enable) |-> !analog_ctrl.neg_use_mux && analog_ctrl.neg_channel == 3'h0;
   endproperty
   a_mux_off: assert property (p_mux_off) else $error("mux used while converter runs");
endmodule : cmp_ctrl_checker
bind comparator_irq_mux_ctrl cmp_ctrl_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
   .cmp_raw(cmp_raw), .converter_enable(converter_enable), .channel_select(channel_select),
   .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .cmp_irq_req(cmp_irq_req),
   .capture_trigger(capture_trigger), .analog_ctrl(analog_ctrl));

// >>> sim/tb_top.sv
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`include "cmp_consts.svh"
module tb_top;
   import cmp_pkg::*;
   localparam logic [7:0] ctl = `CMP_OFS_CTRL;
   logic sys_clk, rst_n, converter_enable, global_irq_enable, vector_ack, pin_above, cmp_raw;
   logic cmp_irq_req, irq, capture_trigger, capture_irq_enable, capture_irq;
   logic [2:0] channel_select;
   logic [7:0] chan_above, rdata, rv;
   bus_req_t bus_req;
   analog_ctrl_t analog_ctrl;
   int err_count = 0;
   int samples_checked = 0;
   comparator_irq_mux_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .cmp_raw(cmp_raw), .converter_enable(converter_enable), .channel_select(channel_select),
      .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .cmp_irq_req(cmp_irq_req), .irq(irq),
      .capture_trigger(capture_trigger), .analog_ctrl(analog_ctrl));
   cmp_analog_model u_far (.analog_ctrl(analog_ctrl), .pin_above(pin_above), .chan_above(chan_above),
      .capture_trigger(capture_trigger), .capture_irq_enable(capture_irq_enable), .cmp_raw(cmp_raw),
      .capture_irq(capture_irq));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 rv = rdata;
   endtask : rd
   // hold long enough for the synchroniser and the edge stage to settle
   task raw(input logic v);
      @(posedge sys_clk);
      pin_above <= v;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : raw
   task wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      wrap_up;
   end
   initial
   begin
      rst_n = 1'b0;
      bus_req = '0;
      converter_enable = 1'b0;
      channel_select = 3'h0;
      global_irq_enable = 1'b1;
      vector_ack = 1'b0;
      capture_irq_enable = 1'b1;
      pin_above = 1'b0;
      chan_above = 8'h00;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ctl);
      chk("ctrl", 8'h00, rv);
      rd(8'h20);
      chk("unmapped", 8'h00, rv);
      $display("reset test done");
      for (int m = 0; m < 4; m++)
      begin
         wr(ctl, 8'h10 | m[7:0]);
         wr(ctl, 8'h18 | m[7:0]);
         raw(1'b1);
         chk("req rise", {7'h0, m == 0 || m == 3}, {7'h0, cmp_irq_req});
         rd(ctl);
         chk("ctrl rise", {3'h1, m == 0 || m == 3, 2'h2, m[1:0]}, rv);
         wr(ctl, 8'h18 | m[7:0]);
         raw(1'b0);
         rd(ctl);
         chk("ctrl fall", {3'h0, m == 0 || m == 2, 2'h2, m[1:0]}, rv);
      end
      $display("mode test done");
      @(posedge sys_clk);
      global_irq_enable <= 1'b0;
      raw(1'b1);
      chk("req masked", 8'h00, {7'h0, cmp_irq_req});
      wr(ctl, 8'h08);
      rd(ctl);
      chk("flag kept", 8'h38, rv);
      @(posedge sys_clk);
      global_irq_enable <= 1'b1;
      @(posedge sys_clk);
      #1 chk("req global", 8'h01, {7'h0, cmp_irq_req});
      wr(ctl, 8'h00);
      #1 chk("req off", 8'h00, {7'h0, cmp_irq_req});
      wr(ctl, 8'h08);
      #1 chk("req on", 8'h01, {7'h0, cmp_irq_req});
      @(posedge sys_clk);
      vector_ack <= 1'b1;
      @(posedge sys_clk);
      vector_ack <= 1'b0;
      rd(ctl);
      chk("ctrl vector", 8'h28, rv);
      $display("request test done");
      wr(ctl, 8'h04);
      raw(1'b1);
      chk("trigger", 8'h01, {7'h0, capture_trigger});
      chk("capture irq", 8'h01, {7'h0, capture_irq});
      wr(ctl, 8'h00);
      raw(1'b1);
      chk("trigger off", 8'h00, {7'h0, capture_trigger});
      chk("capture irq off", 8'h00, {7'h0, capture_irq});
      wr(`CMP_OFS_EVT_CLR, 8'h07);
      wr(`CMP_OFS_EVT_EN, 8'h04);
      raw(1'b0);
      rd(`CMP_OFS_EVT_STAT);
      chk("status", 8'h05, rv);
      chk("irq", 8'h01, {7'h0, irq});
      wr(`CMP_OFS_EVT_EN, 8'h02);
      #1 chk("irq masked", 8'h00, {7'h0, irq});
      wr(`CMP_OFS_EVT_CLR, 8'h05);
      rd(`CMP_OFS_EVT_STAT);
      chk("status clr", 8'h00, rv);
      $display("capture and event test done");
      // reserved mode and a flag clear, so channel switching cannot raise the flag
      wr(ctl, 8'h11);
      wr(`CMP_OFS_MUX, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         @(posedge sys_clk);
         channel_select <= c[2:0];
         chan_above <= 8'h01 << c;
         rd(ctl);
         raw(1'b0);
         chk("channel", {5'h0, c[2:0]}, {5'h0, analog_ctrl.neg_channel});
         rd(ctl);
         chk("ctrl mux", 8'h21, rv);
      end
      @(posedge sys_clk);
      converter_enable <= 1'b1;
      raw(1'b0);
      chk("mux off", 8'h00, {7'h0, analog_ctrl.neg_use_mux});
      rd(ctl);
      chk("ctrl pin", 8'h01, rv);
      wr(ctl, 8'hC0);
      raw(1'b0);
      chk("power", 8'h03, {6'h0, analog_ctrl.power_down, analog_ctrl.bandgap_sel});
      $display("mux test done");
      wrap_up;
   end
endmodule : tb_top
